// File: bench/cad_decoder_assertions.sv
// port assertions of the decoder, bound to every decoder instance
module cad_decoder_assertions
    import cad_pkg::*;
(
    input wire logic        clk_in,          // core clock
    input wire logic        sys_rst_in,      // async reset, high
    input wire logic        fetch_ready_out, // decoder takes bytes
    input wire logic [7:0]  x_in,            // index register x
    input wire logic [7:0]  y_in,            // index register y
    input wire logic        mem_rd_req_out,  // pointer read request
    input wire logic [15:0] mem_rd_addr_out, // pointer read address
    input wire logic        mem_rd_ack_in,   // read data valid
    input wire cad_dec_s    dec_out,         // decoded instruction
    input wire logic        illegal_rst_out  // illegal code reset
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic      dv = dec_out.valid; // decode pulse
    wire cad_mode_e md = dec_out.mode;  // decoded mode
    // a pointer read still waiting, and one being answered
    sequence s_wait; mem_rd_req_out && !mem_rd_ack_in; endsequence
    sequence s_take; mem_rd_req_out && mem_rd_ack_in; endsequence
    property p_hold; s_wait |=> mem_rd_req_out && $stable(mem_rd_addr_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pointer read moved before its answer");
    // a word pointer is read from two consecutive bytes
    property p_step; s_take |=> !mem_rd_req_out
        || mem_rd_addr_out == $past(mem_rd_addr_out) + 16'h0001; endproperty
    a_step: assert property (p_step)
        else $error("pointer read address did not step by one");
    property p_len; dv |-> dec_out.length inside {[3'h1:3'h4]}; endproperty
    a_len: assert property (p_len)
        else $error("instruction length out of range");
    property p_imm; dv && md == CAD_AM_IMM
        |-> dec_out.length == (dec_out.use_y ? 3'h3 : 3'h2); endproperty
    a_imm: assert property (p_imm)
        else $error("immediate length wrong");
    property p_noofs; dv && md == CAD_AM_NOOFS |-> dec_out.ea
        == {8'h00, dec_out.use_y ? $past(y_in) : $past(x_in)}; endproperty
    a_noofs: assert property (p_noofs)
        else $error("no-offset address is not the index");
    property p_sidx; dv && md inside {CAD_AM_SIDX, CAD_AM_SIIDX}
        |-> dec_out.ea <= 16'h01FE; endproperty
    a_sidx: assert property (p_sidx)
        else $error("short indexed address above 1FE");
    property p_page; dv && md inside {CAD_AM_SDIR, CAD_AM_SIND}
        |-> dec_out.ea[15:8] == 8'h00; endproperty
    a_page: assert property (p_page)
        else $error("short address left page zero");
    property p_ill; illegal_rst_out |-> !dv ##1 !illegal_rst_out; endproperty
    a_ill: assert property (p_ill)
        else $error("illegal reset not a lone pulse");
    property p_rdy; dv |-> fetch_ready_out; endproperty
    a_rdy: assert property (p_rdy)
        else $error("not ready for the next instruction");
endmodule

bind cad_decoder cad_decoder_assertions u_chk (.clk_in, .sys_rst_in,
    .fetch_ready_out, .x_in, .y_in, .mem_rd_req_out, .mem_rd_addr_out,
    .mem_rd_ack_in, .dec_out, .illegal_rst_out);

// File: bench/cad_mem_model.sv
// program memory model: code byte stream and page-zero pointer reads
module cad_mem_model (
    input  wire logic        clk_in,               // core clock
    input  wire logic        fetch_ready_in,       // decoder takes bytes
    output logic             fetch_valid_out = 0,  // code byte offered
    output logic [7:0]       fetch_byte_out = 0,   // code byte
    input  wire logic        rd_req_in,            // pointer read request
    input  wire logic [15:0] rd_addr_in,           // pointer read address
    output logic             rd_ack_out = 0,       // read data valid
    output logic [7:0]       rd_data_out = 0       // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    int         code[$];     // bytes still to offer
    logic [7:0] mem [0:255]; // page zero, only place pointers live
    int         lat = 1;     // answer latency, at least one cycle
    int         cnt = 0;     // cycles waited on this byte
    // idle lines toggle so a stale byte can never pass as fresh data
    always @(posedge clk_in) begin
        if (fetch_valid_out && fetch_ready_in)
            void'(code.pop_front());
        #1;
        fetch_valid_out = code.size() > 0;
        fetch_byte_out = fetch_valid_out ? 8'(code[0]) : ~fetch_byte_out;
    end
    // one ack per byte, never in the cycle the request rises
    always @(posedge clk_in) begin
        #1;
        if (rd_req_in && !rd_ack_out && cnt >= lat) begin
            rd_ack_out = 1;
            rd_data_out = mem[rd_addr_in[7:0]];
            cnt = 0;
        end else begin
            rd_ack_out = 0;
            rd_data_out = ~rd_data_out;
            cnt = rd_req_in ? cnt + 1 : 0;
        end
    end
endmodule

// File: bench/cpu_addressing_mode_decoder_test.sv
// self-checking bench of the addressing-mode decoder
module cpu_addressing_mode_decoder_test
    import cad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 0;      // core clock, 100 ns
    logic        rst = 1;         // reset, high
    logic        ld = 0;          // fetch pointer reload
    logic [15:0] ldv = 0;         // reload value
    logic [7:0]  x = 0;           // index x
    logic [7:0]  y = 0;           // index y
    logic        fv, rdy, rq, ak, ill; // stream, read and reset lines
    logic [7:0]  fb, rd;          // code byte, read data
    logic [15:0] ra;              // read address
    cad_dec_s    dec;             // decoded instruction
    int          fail_count = 0;  // mismatches
    int          num_checks = 0;  // comparisons
    int          pc;              // model fetch pointer
    always #50 clk_in = ~clk_in;
    cad_decoder dut (.clk_in, .sys_rst_in(rst), .ce_in(1'b1),
        .fetch_valid_in(fv), .fetch_byte_in(fb), .fetch_ready_out(rdy),
        .pc_load_in(ld), .pc_value_in(ldv), .x_in(x), .y_in(y),
        .mem_rd_req_out(rq), .mem_rd_addr_out(ra), .mem_rd_ack_in(ak),
        .mem_rd_data_in(rd), .dec_out(dec), .illegal_rst_out(ill));
    cad_mem_model pm (.clk_in, .fetch_ready_in(rdy), .fetch_valid_out(fv),
        .fetch_byte_out(fb), .rd_req_in(rq), .rd_addr_in(ra),
        .rd_ack_out(ak), .rd_data_out(rd));
    task chk(input bit bad, input string s);
        num_checks++;
        if (bad) begin
            fail_count++;
            $display("mismatch %0t %s", $time, s);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // reference: feed one instruction, expect m (-1 = illegal) and y use
    task run(input int b[$], input int m, input bit uy);
        int k, a0, a1, ix, w, p, ea, n, t;
        @(posedge clk_in);
        #1;
        x = 8'($urandom);
        y = 8'($urandom);
        pm.lat = 1 + $urandom % 3;
        k = 0;
        n = b.size();
        while (b[k] inside {[144:146]}) k++;
        a0 = b[k+1];
        a1 = b[k+2];
        ix = uy ? y : x;
        p = pm.mem[a0[7:0]];
        w = p * 256 + pm.mem[8'(a0 + 1)];
        case (m)
            CAD_AM_SDIR: ea = a0;
            CAD_AM_LDIR: ea = a0 * 256 + a1;
            CAD_AM_NOOFS: ea = ix;
            CAD_AM_SIDX: ea = a0 + ix;
            CAD_AM_LIDX: ea = a0 * 256 + a1 + ix;
            CAD_AM_SIND: ea = p;
            CAD_AM_LIND: ea = w;
            CAD_AM_SIIDX: ea = p + ix;
            CAD_AM_LIIDX: ea = w + ix;
            CAD_AM_BIT, CAD_AM_BTJ: ea = a0;
            CAD_AM_BITIND, CAD_AM_BTJIND: ea = p;
            default: ea = 0;
        endcase
        // branch target: after the whole instruction plus signed offset
        t = m == CAD_AM_REL ? a0 : m == CAD_AM_RELIND ? p : a1;
        t = m inside {CAD_AM_REL, CAD_AM_RELIND, CAD_AM_BTJ, CAD_AM_BTJIND}
            ? pc + n + $signed(8'(t)) : 0;
        foreach (b[i]) pm.code.push_back(b[i]);
        for (int c = 0; c < 80; c++) begin
            @(posedge clk_in);
            #2;
            if (dec.valid === 1'b1 || ill === 1'b1) break;
        end
        if (m < 0)
            chk(ill !== 1'b1 || dec.valid !== 1'b0, "no reset");
        else begin
            chk(ill !== 1'b0 || dec.valid !== 1'b1
                || dec.use_y !== uy || dec.mode !== cad_mode_e'(m)
                || dec.length !== 3'(n) || dec.opcode !== 8'(b[k])
                || dec.ea !== 16'(ea), "decode");
            if (m == CAD_AM_IMM)
                chk(dec.operand !== 8'(a0), "operand");
            chk(dec.target !== 16'(t), "target");
        end
        pc = pc + n;
    endtask
    initial begin
        #1_000_000;
        fail_count++;
        summarize;
    end
    initial begin
        void'($urandom(45524));
        foreach (pm.mem[i]) pm.mem[i] = 8'($urandom);
        repeat (3) @(posedge clk_in);
        #1;
        rst = 0;
        ld = 1;
        ldv = 16'h7FF0;
        pc = 'h7FF0;
        @(posedge clk_in);
        #1;
        ld = 0;
        run('{'hA6, 'h55}, CAD_AM_IMM, 0);
        run('{'h90, 'hA6, 'h55}, CAD_AM_IMM, 1);
        run('{'h92, 'hB6, 'h10}, CAD_AM_SIND, 0);
        run('{'hB6, 'hFF}, CAD_AM_SDIR, 0);
        run('{'hC6, 'h12, 'h34}, CAD_AM_LDIR, 0);
        run('{'hF6}, CAD_AM_NOOFS, 0);
        run('{'h90, 'hF6}, CAD_AM_NOOFS, 1);
        run('{'hE6, 'hFF}, CAD_AM_SIDX, 0);
        run('{'hD6, 'hFF, 'hFE}, CAD_AM_LIDX, 0);
        run('{'h92, 'hC6, 'h20}, CAD_AM_LIND, 0);
        run('{'h92, 'hE6, 'h30}, CAD_AM_SIIDX, 0);
        run('{'h91, 'hE6, 'h40}, CAD_AM_SIIDX, 1);
        run('{'h92, 'hD6, 'h50}, CAD_AM_LIIDX, 0);
        run('{'h20, 'h80}, CAD_AM_REL, 0);
        run('{'h92, 'h20, 'h60}, CAD_AM_RELIND, 0);
        run('{'hAD, 'h7F}, CAD_AM_REL, 0);
        run('{'h92, 'h42}, CAD_AM_INH, 0);
        run('{'h01, 'h44, 'h10}, CAD_AM_BTJ, 0);
        run('{'h92, 'h11, 'h70}, CAD_AM_BITIND, 0);
        run('{'h92, 'h01, 'h70, 'hF0}, CAD_AM_BTJIND, 0);
        run('{'h31}, -1, 0);
        summarize;
    end
endmodule

// File: core/cad_decoder.sv
// instruction fetch, prebyte handling and effective address formation
module cad_decoder
    import cad_pkg::*;
(
    input  wire logic        clk_in,          // core clock, 10 MHz
    input  wire logic        sys_rst_in,      // async reset, active high
    input  wire logic        ce_in,           // clock enable, low freezes
    input  wire logic        fetch_valid_in,  // code byte offered
    input  wire logic [7:0]  fetch_byte_in,   // code byte
    output logic             fetch_ready_out, // code byte taken if valid
    input  wire logic        pc_load_in,      // reload fetch pointer
    input  wire logic [15:0] pc_value_in,     // new fetch pointer
    input  wire logic [7:0]  x_in,            // index register x
    input  wire logic [7:0]  y_in,            // index register y
    output logic             mem_rd_req_out,  // pointer read request
    output logic [15:0]      mem_rd_addr_out, // pointer read address
    input  wire logic        mem_rd_ack_in,   // read data valid
    input  wire logic [7:0]  mem_rd_data_in,  // read data
    output cad_dec_s         dec_out,         // decoded instruction
    output logic             illegal_rst_out  // illegal code reset pulse
);

    // sequencer states
    typedef enum logic [2:0] {
        CAD_S_OPC, CAD_S_CLS, CAD_S_ARG, CAD_S_RD, CAD_S_OUT
    } cad_state_e;

    cad_state_e  state;       // current state
    cad_state_e  next_state;  // next state
    cad_pfx_e    pfx;         // prebyte held for the next opcode
    logic [7:0]  opcode;      // opcode captured
    logic [2:0]  length;      // bytes consumed so far
    cad_mode_e   mode;        // resolved mode
    logic        use_y;       // y selected as index
    logic [1:0]  args_left;   // bytes still to fetch after opcode
    logic [1:0]  arg_cnt;     // bytes fetched after opcode
    logic [7:0]  arg0;        // first byte after opcode
    logic [7:0]  arg1;        // second byte after opcode
    logic [1:0]  ptr_left;    // pointer bytes still to read
    logic [7:0]  ptr0;        // first pointer byte (high for words)
    logic [7:0]  ptr1;        // second pointer byte (low)
    logic [15:0] fetch_pc;    // address of the next code byte
    cad_cls_s    cls;         // table entry of the opcode

    // number of bytes that follow the opcode in each mode
    function automatic logic [1:0] args_of(input cad_mode_e m);
        case (m)
            CAD_AM_INH, CAD_AM_NOOFS: return 2'h0;
            CAD_AM_LDIR, CAD_AM_LIDX: return MAX_ARGS;
            CAD_AM_BTJ, CAD_AM_BTJIND: return MAX_ARGS;
            default: return 2'h1;
        endcase
    endfunction

    // number of pointer bytes read from memory in each mode
    function automatic logic [1:0] ptrs_of(input cad_mode_e m);
        case (m)
            CAD_AM_LIND, CAD_AM_LIIDX: return MAX_PTR;
            CAD_AM_SIND, CAD_AM_SIIDX: return 2'h1;
            CAD_AM_RELIND, CAD_AM_BITIND: return 2'h1;
            CAD_AM_BTJIND: return 2'h1;
            default: return 2'h0;
        endcase
    endfunction

    // sign extension of a displacement byte
    function automatic logic [15:0] sext(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction

    // table lookup, registered; addressed by the byte being taken
    wire take_w = fetch_valid_in & fetch_ready_out;  // byte accepted
    wire is_pfx_w = (fetch_byte_in == Y_SUBSTITUTE_PREFIX) ||
                    (fetch_byte_in == INDIRECT_X_PREFIX) ||
                    (fetch_byte_in == INDIRECT_Y_PREFIX);
    wire opc_take_w = take_w && state == CAD_S_OPC && !is_pfx_w;

    cad_op_rom u_rom (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .rd_en_in   (opc_take_w),
        .code_in    (fetch_byte_in),
        .cls_out    (cls)
    );

    // prebyte applied to the row class; unauthorised pairs fall back
    // to the plain form rather than a reset
    cad_mode_e res_mode_w;   // resolved mode
    logic      res_y_w;      // resolved index choice
    always_comb begin
        res_mode_w = CAD_AM_INH;
        res_y_w    = (pfx == CAD_P_Y);
        case (cls.base)
            CAD_B_INH:   res_mode_w = CAD_AM_INH;
            CAD_B_IMM:   res_mode_w = CAD_AM_IMM;
            CAD_B_NOOFS: res_mode_w = CAD_AM_NOOFS;
            CAD_B_SDIR:  res_mode_w = (pfx == CAD_P_IX) ?
                                      CAD_AM_SIND : CAD_AM_SDIR;
            CAD_B_LDIR:  res_mode_w = (pfx == CAD_P_IX) ?
                                      CAD_AM_LIND : CAD_AM_LDIR;
            CAD_B_REL:   res_mode_w = (pfx == CAD_P_IX) ?
                                      CAD_AM_RELIND : CAD_AM_REL;
            CAD_B_BIT:   res_mode_w = (pfx == CAD_P_IX) ?
                                      CAD_AM_BITIND : CAD_AM_BIT;
            CAD_B_BTJ:   res_mode_w = (pfx == CAD_P_IX) ?
                                      CAD_AM_BTJIND : CAD_AM_BTJ;
            CAD_B_SIDX: begin
                if (pfx == CAD_P_IX || pfx == CAD_P_IY)
                    res_mode_w = CAD_AM_SIIDX;
                else
                    res_mode_w = CAD_AM_SIDX;
                if (pfx == CAD_P_IY)
                    res_y_w = 1'b1;
            end
            CAD_B_LIDX: begin
                if (pfx == CAD_P_IX || pfx == CAD_P_IY)
                    res_mode_w = CAD_AM_LIIDX;
                else
                    res_mode_w = CAD_AM_LIDX;
                if (pfx == CAD_P_IY)
                    res_y_w = 1'b1;
            end
            default: res_mode_w = CAD_AM_INH;
        endcase
    end

    // address arithmetic, all unsigned except the displacement
    wire [15:0] idx_w    = {8'h00, use_y ? y_in : x_in};  // index zero-ext
    wire [15:0] word_a_w = {arg0, arg1};                 // inline word
    wire [15:0] word_p_w = {ptr0, ptr1};                 // pointer word
    wire [15:0] short_a_w = {8'h00, arg0};               // inline byte
    wire [15:0] short_p_w = {8'h00, ptr0};               // pointer byte
    logic [15:0] ea_w;      // effective address
    logic [15:0] target_w;  // branch target
    always_comb begin
        ea_w     = ADDR_ZERO;
        target_w = ADDR_ZERO;
        case (mode)
            CAD_AM_SDIR:   ea_w = short_a_w;
            CAD_AM_LDIR:   ea_w = word_a_w;
            CAD_AM_NOOFS:  ea_w = idx_w;
            CAD_AM_SIDX:   ea_w = short_a_w + idx_w;
            CAD_AM_LIDX:   ea_w = word_a_w + idx_w;
            CAD_AM_SIND:   ea_w = short_p_w;
            CAD_AM_LIND:   ea_w = word_p_w;
            CAD_AM_SIIDX:  ea_w = short_p_w + idx_w;
            CAD_AM_LIIDX:  ea_w = word_p_w + idx_w;
            CAD_AM_BIT:    ea_w = short_a_w;
            CAD_AM_BITIND: ea_w = short_p_w;
            CAD_AM_REL:    target_w = fetch_pc + sext(arg0);
            CAD_AM_RELIND: target_w = fetch_pc + sext(ptr0);
            CAD_AM_BTJ: begin
                ea_w     = short_a_w;
                target_w = fetch_pc + sext(arg1);
            end
            CAD_AM_BTJIND: begin
                ea_w     = short_p_w;
                target_w = fetch_pc + sext(arg1);
            end
            default: ea_w = ADDR_ZERO;
        endcase
    end

    // next state; pointer reads only after all inline bytes are in
    always_comb begin
        next_state = state;
        case (state)
            CAD_S_OPC: if (opc_take_w) next_state = CAD_S_CLS;
            CAD_S_CLS: begin
                if (!cls.legal)
                    next_state = CAD_S_OPC;
                else if (args_of(res_mode_w) != 2'h0)
                    next_state = CAD_S_ARG;
                else
                    next_state = CAD_S_OUT;
            end
            CAD_S_ARG: begin
                if (take_w && args_left == 2'h1)
                    next_state = (ptrs_of(mode) != 2'h0) ? CAD_S_RD
                                                         : CAD_S_OUT;
            end
            CAD_S_RD:
                if (mem_rd_ack_in && ptr_left == 2'h1)
                    next_state = CAD_S_OUT;
            CAD_S_OUT: next_state = CAD_S_OPC;
            default: next_state = CAD_S_OPC;
        endcase
    end

    // state and fetch handshake; ready stays registered
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state           <= CAD_S_OPC;
            fetch_ready_out <= 1'b0;
        end else if (ce_in) begin
            state           <= next_state;
            fetch_ready_out <= (next_state == CAD_S_OPC) ||
                               (next_state == CAD_S_ARG);
        end
    end

    // fetch pointer counts every byte taken; a reload from the datapath
    // wins since it redirects the stream
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            fetch_pc <= PC_RESET;
        else if (ce_in && pc_load_in)
            fetch_pc <= pc_value_in;
        else if (ce_in && take_w)
            fetch_pc <= fetch_pc + 16'h0001;
    end

    // prebyte capture: a later prebyte replaces an earlier one, the
    // opcode that follows consumes it
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pfx <= CAD_P_NONE;
        end else if (ce_in && take_w && state == CAD_S_OPC) begin
            case (fetch_byte_in)
                Y_SUBSTITUTE_PREFIX: pfx <= CAD_P_Y;
                INDIRECT_X_PREFIX:   pfx <= CAD_P_IX;
                INDIRECT_Y_PREFIX:   pfx <= CAD_P_IY;
                default:             pfx <= pfx;
            endcase
        end else if (ce_in && state == CAD_S_CLS) begin
            pfx <= CAD_P_NONE;
        end
    end

    // opcode, length and mode bookkeeping
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            opcode    <= BYTE_ZERO;
            length    <= 3'h0;
            mode      <= CAD_AM_INH;
            use_y     <= 1'b0;
            args_left <= 2'h0;
        end else if (ce_in) begin
            if (state == CAD_S_OPC && take_w) begin
                opcode <= fetch_byte_in;
                length <= is_pfx_w ? LEN_PREFIX
                                   : (pfx != CAD_P_NONE ? 3'h2 : 3'h1);
            end else if (state == CAD_S_CLS) begin
                mode      <= res_mode_w;
                use_y     <= res_y_w;
                args_left <= args_of(res_mode_w);
            end else if (state == CAD_S_ARG && take_w) begin
                length    <= length + 3'h1;
                args_left <= args_left - 2'h1;
            end
        end
    end

    // inline bytes after the opcode, in stream order
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            arg_cnt <= 2'h0;
            arg0    <= BYTE_ZERO;
            arg1    <= BYTE_ZERO;
        end else if (ce_in) begin
            if (state == CAD_S_CLS)
                arg_cnt <= 2'h0;
            else if (state == CAD_S_ARG && take_w) begin
                arg_cnt <= arg_cnt + 2'h1;
                if (arg_cnt == 2'h0)
                    arg0 <= fetch_byte_in;
                else
                    arg1 <= fetch_byte_in;
            end
        end
    end

    // pointer reads: first byte at the address byte, second one above;
    // the request stays high until the last acknowledge
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_rd_req_out  <= 1'b0;
            mem_rd_addr_out <= ADDR_ZERO;
            ptr_left        <= 2'h0;
            ptr0            <= BYTE_ZERO;
            ptr1            <= BYTE_ZERO;
        end else if (ce_in) begin
            if (state == CAD_S_ARG && next_state == CAD_S_RD) begin
                mem_rd_req_out  <= 1'b1;
                mem_rd_addr_out <= {8'h00, arg_cnt == 2'h0 ?
                                   fetch_byte_in : arg0};
                ptr_left        <= ptrs_of(mode);
            end else if (state == CAD_S_RD && mem_rd_ack_in) begin
                if (ptr_left == ptrs_of(mode))
                    ptr0 <= mem_rd_data_in;
                else
                    ptr1 <= mem_rd_data_in;
                ptr_left        <= ptr_left - 2'h1;
                mem_rd_addr_out <= mem_rd_addr_out + 16'h0001;
                mem_rd_req_out  <= (ptr_left != 2'h1);
            end
        end
    end

    // decoded result and illegal-code reset, both one-cycle pulses;
    // a prebyte is never judged illegal, and a legal opcode after any
    // prebyte decodes without reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dec_out         <= '0;
            illegal_rst_out <= 1'b0;
        end else if (ce_in) begin
            illegal_rst_out <= state == CAD_S_CLS
                               && !cls.legal;
            dec_out.valid   <= state == CAD_S_OUT;
            if (state == CAD_S_OUT) begin
                dec_out.opcode  <= opcode;
                dec_out.mode    <= mode;
                dec_out.use_y   <= use_y;
                dec_out.length  <= length;
                dec_out.operand <= arg0;
                dec_out.ea      <= ea_w;
                dec_out.target  <= target_w;
            end
        end
    end

endmodule

// File: core/cad_op_rom.sv
// registered opcode classification table of the decoder
module cad_op_rom
    import cad_pkg::*;
(
    input  wire logic     clk_in,     // core clock
    input  wire logic     sys_rst_in, // async reset, active high
    input  wire logic     ce_in,      // clock enable
    input  wire logic     rd_en_in,   // load a new entry
    input  wire logic [7:0] code_in,  // opcode used as address
    output cad_cls_s      cls_out     // registered class
);

    // row-by-row class of each code; undefined codes are not legal
    function automatic cad_cls_s class_of(input logic [7:0] op);
        cad_cls_s   c;
        logic [3:0] lo;
        c.legal = 1'b1;
        c.base  = CAD_B_INH;
        lo      = op[3:0];
        case (op[OP_ROW_MSB:OP_ROW_LSB])
            4'h0: c.base = CAD_B_BTJ;
            4'h1: c.base = CAD_B_BIT;
            4'h2: c.base = CAD_B_REL;
            4'h3: c.base = CAD_B_SDIR;
            4'h4, 4'h5: c.base = CAD_B_INH;
            4'h6: c.base = CAD_B_SIDX;
            4'h7: c.base = CAD_B_NOOFS;
            4'h8, 4'h9: c.base = CAD_B_INH;
            4'hA: c.base = (op == OP_REL_CALL) ? CAD_B_REL : CAD_B_IMM;
            4'hB: c.base = CAD_B_SDIR;
            4'hC: c.base = CAD_B_LDIR;
            4'hD: c.base = CAD_B_LIDX;
            4'hE: c.base = CAD_B_SIDX;
            default: c.base = CAD_B_NOOFS;
        endcase
        // holes in the read-modify-write rows
        if (op[7:4] >= 4'h3 && op[7:4] <= 4'h7 && op != OP_MULTIPLY &&
            (lo == 4'h1 || lo == 4'h2 || lo == 4'h5 || lo == 4'hB))
            c.legal = 1'b0;
        // holes in the inherent and immediate rows
        if (op[7:4] == 4'h8 && (lo == 4'h2 || lo == 4'h3 || lo == 4'h6 ||
            lo == 4'h7 || lo == 4'hC || lo == 4'hD))
            c.legal = 1'b0;
        if (op[7:4] == 4'h9 && lo <= 4'h2)
            c.legal = 1'b0;
        if (op[7:4] == 4'hA && (lo == 4'h7 || lo == 4'hC))
            c.legal = 1'b0;
        return c;
    endfunction

    cad_cls_s table_w [OPCODE_COUNT]; // constant table

    // one table entry per code
    for (genvar i = 0; i < OPCODE_COUNT; i++) begin : g_tab
        assign table_w[i] = class_of(8'(i));
    end

    // read data comes out of a register, one cycle after the address
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cls_out <= '0;
        end else if (ce_in && rd_en_in) begin
            cls_out <= table_w[code_in];
        end
    end

endmodule

// File: core/cad_pkg.sv
// shared constants, enumerations and carriers of the addressing-mode decoder
package cad_pkg;

    // prebyte codes
    localparam logic [7:0] Y_SUBSTITUTE_PREFIX = 8'h90; // x forms become y
    localparam logic [7:0] INDIRECT_Y_PREFIX   = 8'h91; // x ind-idx -> y
    localparam logic [7:0] INDIRECT_X_PREFIX   = 8'h92; // direct -> indirect

    // opcode fields and special codes
    localparam int         OP_ROW_MSB   = 7;      // row nibble, top bit
    localparam int         OP_ROW_LSB   = 4;      // row nibble, low bit
    localparam logic [7:0] OP_MULTIPLY  = 8'h42;  // only code exempt from the row 3-7 holes
    localparam logic [7:0] OP_REL_CALL  = 8'hAD;  // relative_subroutine_call
    localparam int         OPCODE_COUNT = 256;    // table entries

    // sizes and reset values
    localparam logic [15:0] PC_RESET    = 16'h0000; // fetch pointer at reset
    localparam logic [15:0] ADDR_ZERO   = 16'h0000; // cleared address
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;    // cleared byte
    localparam logic [2:0]  LEN_PREFIX  = 3'h1;     // a prebyte adds one
    localparam logic [1:0]  MAX_ARGS    = 2'h2;     // bytes after opcode
    localparam logic [1:0]  MAX_PTR     = 2'h2;     // pointer bytes read

    // row classes that the opcode table yields, before prebytes apply
    typedef enum logic [3:0] {
        CAD_B_INH, CAD_B_IMM, CAD_B_SDIR, CAD_B_LDIR, CAD_B_NOOFS,
        CAD_B_SIDX, CAD_B_LIDX, CAD_B_REL, CAD_B_BIT, CAD_B_BTJ
    } cad_base_e;

    // final addressing modes, seventeen of them
    typedef enum logic [4:0] {
        CAD_AM_INH, CAD_AM_IMM, CAD_AM_SDIR, CAD_AM_LDIR, CAD_AM_NOOFS,
        CAD_AM_SIDX, CAD_AM_LIDX, CAD_AM_SIND, CAD_AM_LIND, CAD_AM_SIIDX,
        CAD_AM_LIIDX, CAD_AM_REL, CAD_AM_RELIND, CAD_AM_BIT,
        CAD_AM_BITIND, CAD_AM_BTJ, CAD_AM_BTJIND
    } cad_mode_e;

    // prebyte currently held
    typedef enum logic [1:0] {
        CAD_P_NONE, CAD_P_Y, CAD_P_IX, CAD_P_IY
    } cad_pfx_e;

    // opcode table entry
    typedef struct packed {
        logic      legal; // code is a defined opcode
        cad_base_e base;  // row class
    } cad_cls_s;

    // decoded instruction handed to the datapath
    typedef struct packed {
        logic        valid;   // one-cycle pulse
        logic [7:0]  opcode;  // opcode byte
        cad_mode_e   mode;    // final addressing mode
        logic        use_y;   // index register y selected
        logic [2:0]  length;  // bytes incl. prebyte, 1..4
        logic [7:0]  operand; // immediate value
        logic [15:0] ea;      // effective address
        logic [15:0] target;  // relative branch target
    } cad_dec_s;

endpackage
